// [core/sysacc_pkg.sv]
// types of the system config bank
// constants live in sysacc_regs.svh
package sysacc_pkg;
    typedef enum logic [1:0]
    {
        SYSACC_RG_ALW = 2'b00,
        SYSACC_RG_PWR = 2'b01,
        SYSACC_RG_CODEC = 2'b10,
        SYSACC_RG_CARD = 2'b11
    } sysacc_region_t;
endpackage

// [core/sysacc_ram.sv]
// backing store for the plain read/write registers of the upper always-open range and the gated ranges
// single port, write and registered read in the same clock
`timescale 1ns/1ps
`default_nettype none
module sysacc_ram #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic ref_clk, // system clock
    input wire logic we, // write strobe
    input wire logic re, // read strobe
    input wire logic [AW-1:0] addr, // word index
    input wire logic [DW-1:0] wdata, // write data
    output logic [DW-1:0] rdata_q // read data, one cycle after re
);
    initial
    begin
        if (AW < 1 || DW < 1)
        begin
            $error("sysacc_ram: bad geometry");
        end
    end

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge ref_clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (re)
        begin
            rdata_q <= mem[addr];
        end
    end
endmodule
`default_nettype wire

// [core/sysacc_regs.svh]
// offsets, bit positions, reset values and timing counts of the system config bank
// assumes 16-bit halfword registers at their printed byte offsets
`ifndef SYSACC_REGS_SVH
`define SYSACC_REGS_SVH

`define SYSACC_ID_OFS 16'h0000
`define SYSACC_STRAP_OFS 16'h0002
`define SYSACC_TO_OFS 16'h0006
`define SYSACC_PLL_OFS 16'h0012
`define SYSACC_MISC_OFS 16'h0014
`define SYSACC_IRQ_STAT_OFS 16'h0300
`define SYSACC_IRQ_MASK_OFS 16'h0302
`define SYSACC_CODEC_EN_OFS 16'h0980
`define SYSACC_CARD_EN_OFS 16'h6000

`define SYSACC_ALW0_LO 16'h0000
`define SYSACC_ALW0_HI 16'h0018
`define SYSACC_ALW1_LO 16'h0300
`define SYSACC_ALW1_HI 16'h030c
`define SYSACC_PWR_LO 16'h0030
`define SYSACC_PWR_HI 16'h0f00
`define SYSACC_CODEC_LO 16'h1000
`define SYSACC_CODEC_HI 16'h17a2
`define SYSACC_CARD_LO 16'h6100
`define SYSACC_CARD_HI 16'h613e

`define SYSACC_TO_INT_DIS_BIT 0
`define SYSACC_TO_RST_DIS_BIT 1
`define SYSACC_TO_STAT_BIT 2
`define SYSACC_PLL_DIS_BIT 0
`define SYSACC_PS_BIT 0
`define SYSACC_EN_BIT 0
`define SYSACC_IRQ_TO_BIT 0
`define SYSACC_IRQ_BLK_BIT 1

`define SYSACC_STRAP_RST 7'h00
`define SYSACC_TO_RST 3'h0
`define SYSACC_PLL_RST 1'b1
`define SYSACC_MISC_RST 16'h0011
`define SYSACC_MISC_WMASK 16'h7fff
`define SYSACC_IRQ_RST 2'h0

`define SYSACC_BUF_KB 224
`define SYSACC_UNIT_KB 4
`define SYSACC_TO_CYC 3

`endif

// [core/sysacc_top.sv]
// system configuration register bank with range access gating and bus timeout watch
// assumes host strobes on ref_clk, host_wait from same-clock host logic, straps asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "sysacc_regs.svh"
module sysacc_top #(
    parameter logic [5:0] PRODUCT_CODE = 6'h2a, // arbitrary value
    parameter logic [1:0] REVISION_CODE = 2'h1, // arbitrary value
    parameter int TO_CYC = `SYSACC_TO_CYC
) (
    input wire logic ref_clk, // 50 MHz system clock
    input wire logic rst_n, // hardware reset, sync, active low
    input wire logic soft_rst, // software reset pulse
    input wire logic [6:0] config_strap_inputs, // strap pins
    input wire logic host_wait, // host bus wait, high = waiting
    input wire logic [15:0] addr, // byte offset
    input wire logic [15:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [15:0] rdata, // read data, cycle after rd
    output logic irq, // level interrupt
    output logic chip_rst_req, // whole chip reset pulse
    output logic clk_src_pll, // 1 = synthesizer feeds clock divider
    output logic power_save, // power save enabled
    output logic codec_en, // image codec enabled
    output logic card_en // card interface enabled
);
    localparam int TCW = 4;
    localparam logic [15:0] ID_VAL = {8'((`SYSACC_BUF_KB) / (`SYSACC_UNIT_KB)), PRODUCT_CODE, REVISION_CODE};

    initial
    begin
        if (TO_CYC < 2 || TO_CYC > 15)
        begin
            $error("sysacc_top: TO_CYC out of range");
        end
    end

    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    logic [6:0] strap_s1_q;
    logic [6:0] strap_s2_q;
    logic [6:0] strap_q;
    logic rst_seen_q;
    logic to_int_dis_q;
    logic to_rst_dis_q;
    logic to_stat_q;
    logic pll_dis_q;
    logic [15:0] misc_q;
    logic codec_en_q;
    logic card_en_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [TCW-1:0] wait_cnt_q;
    logic chip_rst_q;
    logic irq_q;
    logic clk_src_q;
    logic [15:0] rd_data_q;
    logic mem_rd_q;
    logic [15:0] mem_q;

    logic in_alw;
    logic blocked;
    logic wr_ok;
    logic rd_ok;
    logic to_fire;
    logic gated_rst;
    logic mem_hit;
    logic [7:0] mem_idx;
    sysacc_pkg::sysacc_region_t region;

    assign in_alw = in_rng(addr, `SYSACC_ALW0_LO, `SYSACC_ALW0_HI) || in_rng(addr, `SYSACC_ALW1_LO, `SYSACC_ALW1_HI);
    assign blocked = !in_alw &&
        ((misc_q[`SYSACC_PS_BIT] && in_rng(addr, `SYSACC_PWR_LO, `SYSACC_PWR_HI)) ||
        (!codec_en_q && in_rng(addr, `SYSACC_CODEC_LO, `SYSACC_CODEC_HI)) ||
        (!card_en_q && in_rng(addr, `SYSACC_CARD_LO, `SYSACC_CARD_HI)));
    assign wr_ok = wr && !blocked;
    assign rd_ok = rd && !blocked;
    assign to_fire = host_wait && (wait_cnt_q == TCW'(TO_CYC - 1));
    assign gated_rst = soft_rst || chip_rst_q;

    // plain storage words of the upper always-open range and of each gated range, low address bits select the word
    always_comb
    begin
        region = sysacc_pkg::SYSACC_RG_ALW;
        mem_hit = 1'b0;
        if (in_rng(addr, `SYSACC_ALW1_LO + 16'h0004, `SYSACC_ALW1_HI))
        begin
            mem_hit = 1'b1;
        end
        else if (in_rng(addr, `SYSACC_PWR_LO, `SYSACC_PWR_HI) && !in_alw && addr != `SYSACC_CODEC_EN_OFS)
        begin
            region = sysacc_pkg::SYSACC_RG_PWR;
            mem_hit = 1'b1;
        end
        else if (in_rng(addr, `SYSACC_CODEC_LO, `SYSACC_CODEC_HI))
        begin
            region = sysacc_pkg::SYSACC_RG_CODEC;
            mem_hit = 1'b1;
        end
        else if (in_rng(addr, `SYSACC_CARD_LO, `SYSACC_CARD_HI))
        begin
            region = sysacc_pkg::SYSACC_RG_CARD;
            mem_hit = 1'b1;
        end
        mem_idx = {region, addr[6:1]};
    end

    sysacc_ram #(
        .AW(8),
        .DW(16)
    ) u_ram (
        .ref_clk(ref_clk),
        .we(wr_ok && mem_hit),
        .re(rd_ok && mem_hit),
        .addr(mem_idx),
        .wdata(wdata),
        .rdata_q(mem_q)
    );

    // strap synchroniser, not reset so straps flow during reset
    always_ff @(posedge ref_clk)
    begin
        strap_s1_q <= config_strap_inputs;
        strap_s2_q <= strap_s1_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rst_seen_q <= 1'b0;
            strap_q <= `SYSACC_STRAP_RST;
        end
        else if (!rst_seen_q)
        begin
            rst_seen_q <= 1'b1;
            strap_q <= strap_s2_q;
        end
    end

    // base range: hardware reset only
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            to_int_dis_q <= 1'b0;
            to_rst_dis_q <= 1'b0;
            pll_dis_q <= `SYSACC_PLL_RST;
            misc_q <= `SYSACC_MISC_RST;
        end
        else if (wr_ok)
        begin
            if (addr == `SYSACC_TO_OFS)
            begin
                to_int_dis_q <= wdata[`SYSACC_TO_INT_DIS_BIT];
                to_rst_dis_q <= wdata[`SYSACC_TO_RST_DIS_BIT];
            end
            if (addr == `SYSACC_PLL_OFS)
            begin
                pll_dis_q <= wdata[`SYSACC_PLL_DIS_BIT];
            end
            if (addr == `SYSACC_MISC_OFS)
            begin
                misc_q <= wdata & `SYSACC_MISC_WMASK;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            to_stat_q <= 1'b0;
        end
        else if (to_fire)
        begin
            to_stat_q <= 1'b1;
        end
        else if (wr_ok && addr == `SYSACC_TO_OFS && wdata[`SYSACC_TO_INT_DIS_BIT])
        begin
            to_stat_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wait_cnt_q <= '0;
        end
        else if (!host_wait)
        begin
            wait_cnt_q <= '0;
        end
        else if (wait_cnt_q != TCW'(TO_CYC))
        begin
            wait_cnt_q <= wait_cnt_q + TCW'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            chip_rst_q <= 1'b0;
        end
        else
        begin
            chip_rst_q <= to_fire && !to_rst_dis_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            clk_src_q <= 1'b0;
        end
        else
        begin
            clk_src_q <= !pll_dis_q;
        end
    end

    // unit enables fall back on software or timeout reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || gated_rst)
        begin
            codec_en_q <= 1'b0;
            card_en_q <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (addr == `SYSACC_CODEC_EN_OFS)
            begin
                codec_en_q <= wdata[`SYSACC_EN_BIT];
            end
            if (addr == `SYSACC_CARD_EN_OFS)
            begin
                card_en_q <= wdata[`SYSACC_EN_BIT];
            end
        end
    end

    // sticky events, cleared by reading, a new event wins
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irq_stat_q <= `SYSACC_IRQ_RST;
            irq_mask_q <= `SYSACC_IRQ_RST;
        end
        else
        begin
            if (rd && addr == `SYSACC_IRQ_STAT_OFS)
            begin
                irq_stat_q <= {(wr || rd) && blocked, to_fire && !to_int_dis_q};
            end
            else
            begin
                irq_stat_q <= irq_stat_q | {(wr || rd) && blocked, to_fire && !to_int_dis_q};
            end
            if (wr && addr == `SYSACC_IRQ_MASK_OFS)
            begin
                irq_mask_q <= wdata[1:0];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rd_data_q <= 16'h0000;
            mem_rd_q <= 1'b0;
        end
        else
        begin
            rd_data_q <= 16'h0000;
            mem_rd_q <= rd_ok && mem_hit;
            if (rd_ok)
            begin
                case (addr)
                    `SYSACC_ID_OFS: rd_data_q <= ID_VAL;
                    `SYSACC_STRAP_OFS: rd_data_q <= {9'h000, strap_q};
                    `SYSACC_TO_OFS: rd_data_q <= {13'h0000, to_stat_q, to_rst_dis_q, to_int_dis_q};
                    `SYSACC_PLL_OFS: rd_data_q <= {15'h0000, pll_dis_q};
                    `SYSACC_MISC_OFS: rd_data_q <= misc_q;
                    `SYSACC_IRQ_STAT_OFS: rd_data_q <= {14'h0000, irq_stat_q};
                    `SYSACC_IRQ_MASK_OFS: rd_data_q <= {14'h0000, irq_mask_q};
                    `SYSACC_CODEC_EN_OFS: rd_data_q <= {15'h0000, codec_en_q};
                    `SYSACC_CARD_EN_OFS: rd_data_q <= {15'h0000, card_en_q};
                    default: rd_data_q <= 16'h0000;
                endcase
            end
        end
    end

    assign rdata = mem_rd_q ? mem_q : rd_data_q;
    assign irq = irq_q;
    assign chip_rst_req = chip_rst_q;
    assign clk_src_pll = clk_src_q;
    assign power_save = misc_q[`SYSACC_PS_BIT];
    assign codec_en = codec_en_q;
    assign card_en = card_en_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    AST_ALWAYS_OPEN: assert property (rd && addr == `SYSACC_TO_OFS |=>
        rdata == {13'h0000, $past(to_stat_q), $past(to_rst_dis_q), $past(to_int_dis_q)})
        else $error("timeout register not readable");
    AST_PWR_BLOCK: assert property (rd && misc_q[0] && in_rng(addr, `SYSACC_PWR_LO, `SYSACC_PWR_HI) && !in_alw |=>
        rdata == 16'h0000)
        else $error("power gated read not zero");
    AST_CODEC_BLOCK: assert property (rd && !codec_en_q && in_rng(addr, `SYSACC_CODEC_LO, `SYSACC_CODEC_HI) |=>
        rdata == 16'h0000)
        else $error("codec gated read not zero");
    AST_CARD_BLOCK: assert property (wr && !card_en_q && in_rng(addr, `SYSACC_CARD_LO, `SYSACC_CARD_HI) |->
        !u_ram.we)
        else $error("card gated write reached storage");
    AST_ID_READ: assert property (rd && addr == `SYSACC_ID_OFS |=> rdata[15:8] == 8'h38 && rdata[7:0] ==
        {PRODUCT_CODE, REVISION_CODE})
        else $error("id register wrong");
    AST_STRAP_CAPTURE: assert property ($rose(rst_seen_q) |-> strap_q == $past(strap_s2_q))
        else $error("straps not captured at release");
    AST_TIMEOUT_FLAG: assert property (host_wait [*3] ##0 $past(wait_cnt_q, 2) == 0 && TO_CYC == 3 |=>
        to_stat_q)
        else $error("timeout flag not set");
    AST_TIMEOUT_RESET: assert property (to_fire |=> chip_rst_req == !$past(to_rst_dis_q) ##1 !chip_rst_req)
        else $error("timeout chip reset wrong");
    AST_FLAG_CLEAR: assert property (wr && addr == `SYSACC_TO_OFS && wdata[0] && !to_fire |=> !to_stat_q)
        else $error("timeout flag not cleared");
    AST_SOFT_KEEP: assert property (soft_rst && !wr |=> $stable(misc_q) && $stable(pll_dis_q) &&
        !codec_en_q)
        else $error("software reset disturbed base range");
    AST_CLK_SRC: assert property (##1 clk_src_pll == !$past(pll_dis_q))
        else $error("clock source select wrong");

    COV_TIMEOUT: cover property (to_fire ##1 chip_rst_req);
    COV_BLOCKED_RD: cover property (rd && blocked);
    COV_MEM_RD: cover property (rd_ok && mem_hit ##1 mem_rd_q);
    COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

// [sim/sysacc_host_model.sv]
// host cpu model: register port master and bus wait driver
// assumes the bank samples all of it on ref_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module sysacc_host_model (
    input wire logic ref_clk, // system clock
    input wire logic [15:0] rdata, // read data
    output logic [15:0] addr, // byte offset
    output logic [15:0] wdata, // write data
    output logic wr, // write strobe
    output logic rd, // read strobe
    output logic host_wait // bus wait
);
    initial
    begin
        addr = 16'h0000;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        host_wait = 1'b0;
    end
    // callers may set reserved bits, as the misc write of the soft reset test does; released lines show the inverse
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
    task automatic wait_run(input int n);
        @(posedge ref_clk);
        host_wait <= 1'b1;
        repeat (n) @(posedge ref_clk);
        host_wait <= 1'b0;
    endtask
    // no timeout reset while the synthesizer is off
    task automatic guard_timeout(input logic pll_off);
        wr_reg(16'h0006, {14'h0000, pll_off, 1'b0});
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench of the system config bank
// assumes sysacc_host_model as bus master and wait driver
`timescale 1ns/1ps
`default_nettype none
`include "sysacc_regs.svh"
module tb;
    localparam int TO_CYC = 3;
    localparam logic [5:0] PCODE = 6'h15; // arbitrary value
    localparam logic [1:0] RCODE = 2'h2; // arbitrary value
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_rst = 1'b0;
    logic [6:0] strap;
    logic [6:0] strap_exp;
    logic [15:0] addr, wdata, rdata, v, r;
    logic wr, rd, host_wait, irq, chip_rst_req, clk_src_pll, power_save, codec_en, card_en;
    logic [31:0] lfsr = 32'h96af;
    int fail_count = 0;
    int n_tests = 0;
    int rst_pulses = 0;
    logic [15:0] ctl [3] = '{16'h0014, 16'h0980, 16'h6000};
    logic [15:0] on_v [3] = '{16'h0010, 16'h0001, 16'h0001};
    logic [15:0] off_v [3] = '{16'h0011, 16'h0000, 16'h0000};
    logic [15:0] dat [3] = '{16'h0f00, 16'h17a2, 16'h613e};
    sysacc_top #(.PRODUCT_CODE(PCODE), .REVISION_CODE(RCODE), .TO_CYC(TO_CYC)) sysacc_top_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .soft_rst(soft_rst), .config_strap_inputs(strap),
        .host_wait(host_wait), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .chip_rst_req(chip_rst_req), .clk_src_pll(clk_src_pll),
        .power_save(power_save), .codec_en(codec_en), .card_en(card_en));
    sysacc_host_model sysacc_host_model_inst (.ref_clk(ref_clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .host_wait(host_wait));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        if (chip_rst_req === 1'b1)
            rst_pulses <= rst_pulses + 1;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] id_exp();
        return {8'(`SYSACC_BUF_KB / `SYSACC_UNIT_KB), PCODE, RCODE};
    endfunction
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic w16(input logic [15:0] a, input logic [15:0] d);
        sysacc_host_model_inst.wr_reg(a, d);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input string nm);
        sysacc_host_model_inst.rd_reg(a, r);
        chk16(nm, e, r);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic complete_run();
        $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #200000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        strap = lfsr[6:0];
        strap_exp = lfsr[6:0];
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        strap <= ~strap_exp;
        #1;
        chk1("power_save", 1'b1, power_save);
        chk1("codec_en", 1'b0, codec_en);
        chk1("card_en", 1'b0, card_en);
        chk1("clk_src_pll", 1'b0, clk_src_pll);
        w16(16'h0000, 16'hffff);
        rd_chk(16'h0000, id_exp(), "id");
        rd_chk(16'h0002, {9'h000, strap_exp}, "straps");
        rd_chk(16'h0006, 16'h0000, "timeout_reg");
        rd_chk(16'h0012, 16'h0001, "pll_reg");
        rd_chk(16'h0014, 16'h0011, "misc");
        w16(16'h030c, 16'h5a5a);
        rd_chk(16'h030c, 16'h5a5a, "always_open");
        $display("test reset_and_id done");
        for (int i = 0; i < 3; i++)
        begin
            lfsr = lfsr_next(lfsr);
            v = lfsr[15:0];
            w16(ctl[i], on_v[i]);
            w16(dat[i], v);
            w16(ctl[i], off_v[i]);
            w16(dat[i], ~v);
            rd_chk(dat[i], 16'h0000, "blocked_rd");
            rd_chk(16'h0300, 16'h0002, "irq_blocked");
            w16(ctl[i], on_v[i]);
            rd_chk(dat[i], v, "reopened");
        end
        $display("test range_gating done");
        lfsr = lfsr_next(lfsr);
        v = lfsr[15:0] | 16'h8000;
        w16(16'h0014, v);
        @(posedge ref_clk);
        soft_rst <= 1'b1;
        @(posedge ref_clk);
        soft_rst <= 1'b0;
        #1;
        chk1("codec_soft", 1'b0, codec_en);
        chk1("card_soft", 1'b0, card_en);
        rd_chk(16'h0014, v & 16'h7fff, "misc_kept");
        w16(16'h0014, 16'h0010);
        $display("test soft_reset done");
        w16(16'h0980, 16'h0001);
        w16(16'h0302, 16'h0001);
        sysacc_host_model_inst.wait_run(TO_CYC - 1);
        settle(4);
        chk16("pulses_short", 16'h0000, 16'(rst_pulses));
        sysacc_host_model_inst.wait_run(TO_CYC + 2);
        settle(4);
        chk16("pulses", 16'h0001, 16'(rst_pulses));
        chk1("codec_chip_rst", 1'b0, codec_en);
        chk1("irq", 1'b1, irq);
        rd_chk(16'h0006, 16'h0004, "to_flag");
        rd_chk(16'h0300, 16'h0001, "irq_to");
        w16(16'h0006, 16'h0001);
        rd_chk(16'h0006, 16'h0001, "to_cleared");
        chk1("irq_off", 1'b0, irq);
        sysacc_host_model_inst.guard_timeout(1'b1);
        sysacc_host_model_inst.wait_run(TO_CYC);
        settle(4);
        chk16("pulses_dis", 16'h0001, 16'(rst_pulses));
        rd_chk(16'h0006, 16'h0006, "to_flag_dis");
        rd_chk(16'h0300, 16'h0001, "irq_to_dis");
        w16(16'h0006, 16'h0003);
        sysacc_host_model_inst.wait_run(TO_CYC);
        settle(4);
        rd_chk(16'h0300, 16'h0000, "irq_int_dis");
        rd_chk(16'h0006, 16'h0007, "to_flag_int_dis");
        $display("test bus_timeout done");
        w16(16'h0012, 16'h0000);
        settle(2);
        chk1("clk_src_pll_on", 1'b1, clk_src_pll);
        $display("test pll done");
        complete_run();
    end
endmodule
`default_nettype wire
